// ===== design/sa_buf_pkg.sv
// package: register map, field layout and types for the subaddress decoder
package sa_buf_pkg;
    // word offsets on the bus (byte addresses, 32-bit aligned)
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_CFG       = 8'h04;
    localparam logic [7:0] OFS_SEL       = 8'h08;
    localparam logic [7:0] OFS_MODE      = 8'h0C;
    localparam logic [7:0] OFS_EVENT     = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h18;
    // control word field positions
    localparam int GSEL_BIT      = 15;
    localparam int RXM_LSB       = 5;
    localparam int EOM_EN_BIT    = 4;
    localparam int ROLL_EN_BIT   = 3;
    localparam int BCM_LSB       = 0;
    // configuration word field positions
    localparam int CSIZE_LSB     = 9;
    localparam int ENH_BIT       = 1;
    // event register bits
    localparam int EV_EOM_BIT    = 0;
    localparam int EV_ROLL_BIT   = 1;
    // reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] CFG_RST  = 16'h0000;
    localparam logic [1:0]  MASK_RST = 2'h0;
    // number of subaddresses and smallest circular size
    localparam int SA_NUM        = 32;
    localparam int SA_W          = 5;
    localparam logic [13:0] CIRC_BASE = 14'h0080;
    // mode codes
    localparam logic [2:0] CODE_SINGLE = 3'h0;
    localparam logic [2:0] CODE_GCIRC  = 3'h7;

    typedef enum logic [1:0] {
        BUF_SINGLE = 2'b00,
        BUF_CIRC   = 2'b01,
        BUF_DOUBLE = 2'b10
    } buf_mode_t;

    typedef struct packed {
        buf_mode_t   mode;
        logic [13:0] size;
    } buf_sel_t;
endpackage

// ===== design/sa_ctrl_mem.sv
// little memory holding one control word for each subaddress
`timescale 1ns/1ps
module sa_ctrl_mem (
    input  wire logic                          clk,
    input  wire logic                          we,
    input  wire logic [sa_buf_pkg::SA_W-1:0]   waddr,
    input  wire logic [15:0]                   wdata,
    input  wire logic [sa_buf_pkg::SA_W-1:0]   raddr,
    output logic      [15:0]                   rdata
);
    logic [15:0] mem [sa_buf_pkg::SA_NUM];

    // write port; contents are undefined until software loads them
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // registered read, one cycle of latency
    always_ff @(posedge clk) begin
        rdata <= mem[raddr];
    end
endmodule // sa_ctrl_mem

// ===== design/sa_buf_decode.sv
// subaddress receive/broadcast buffer mode decoder with wishbone slave
//
// Contract
// RL1 - global select forces double (code 000) or circular (code 111)
// RL2 - rx mode 000 single, else circular 128-8192
// RL3 - global, rx code 000: double buffering
// RL4 - global, rx code 111: circular, global size
// RL5 - end-of-message irq enabled by bit 4
// RL6 - rollover irq enabled by bit 3
// RL7 - bcast mode 000 single, else circular sizes
// RL8 - global, bcast code 000: double buffering
// RL9 - global, bcast code 111: circular, global size
// RL10 - host enables enhanced buffering before per-subaddress
// RL11 - global with other codes falls back single
`timescale 1ns/1ps
module sa_buf_decode (
    input  wire logic        MCLK,
    input  wire logic        ARST_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    output logic             IRQ
);

    ////////////////////////////////////////////////////////////////////
    // decode functions

    // circular length from a three-bit code: 128 shifted by code-1
    function automatic logic [13:0] circ_len(input logic [2:0] code);
        logic [2:0] sh;
        sh = code - 3'h1;
        circ_len = sa_buf_pkg::CIRC_BASE << sh;
    endfunction

    // one buffer field decoded against global select and global size
    function automatic sa_buf_pkg::buf_sel_t decode_mode(
        input logic       gsel,
        input logic [2:0] code,
        input logic [2:0] gsize);
        sa_buf_pkg::buf_sel_t r;
        r.mode = sa_buf_pkg::BUF_SINGLE;
        r.size = 14'h0000;
        if (!gsel) begin
            // RL2 RL7 per-subaddress decode
            if (code != sa_buf_pkg::CODE_SINGLE) begin
                r.mode = sa_buf_pkg::BUF_CIRC;
                r.size = circ_len(code);
            end
        end else if (code == sa_buf_pkg::CODE_SINGLE) begin
            // RL3 RL8 global double
            r.mode = sa_buf_pkg::BUF_DOUBLE;
        end else if (code == sa_buf_pkg::CODE_GCIRC) begin
            // RL4 RL9 global circular size; code 000 is taken as 128
            r.mode = sa_buf_pkg::BUF_CIRC;
            r.size = (gsize == 3'h0) ? sa_buf_pkg::CIRC_BASE
                                     : circ_len(gsize);
        end
        // RL11 other codes stay single
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // bus strobes

    logic        req;
    logic        wr;
    logic        rd;
    logic        ack_q;
    logic        ack_d;
    logic        lane01;

    // every access answers two cycles after the strobe rises, so the
    // control memory read has settled before read data are sampled
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT = 2'b01,
        BUS_ACK  = 2'b10
    } bus_state_t;
    bus_state_t bus_q;
    bus_state_t bus_d;

    assign req    = WB_CYC_I && WB_STB_I;
    assign lane01 = WB_SEL_I[0] && WB_SEL_I[1];
    assign wr     = (bus_q == BUS_ACK) && WB_WE_I;
    assign rd     = (bus_q == BUS_ACK) && !WB_WE_I;

    // bus sequencer
    always_comb begin
        bus_d = bus_q;
        ack_d = 1'b0;
        case (bus_q)
            BUS_IDLE: begin
                if (req) begin
                    bus_d = BUS_WAIT;
                end
            end
            BUS_WAIT: begin
                bus_d = BUS_ACK;
            end
            BUS_ACK: begin
                ack_d = 1'b1;
                bus_d = BUS_IDLE;
            end
            default: begin
                bus_d = BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bus_q <= BUS_IDLE;
        end else begin
            bus_q <= bus_d;
        end
    end

    assign ack_q    = (bus_q == BUS_ACK);
    assign WB_ACK_O = ack_q && req;

    ////////////////////////////////////////////////////////////////////
    // registers

    logic [15:0]                  cfg_q;
    logic [sa_buf_pkg::SA_W-1:0]  sel_q;
    logic [1:0]                   mask_q;
    logic [1:0]                   stat_q;
    logic [15:0]                  ctrl_rd;
    logic                         mem_we;

    // control words live in memory; address taken from the select reg
    assign mem_we = wr && (WB_ADR_I == sa_buf_pkg::OFS_CTRL) && lane01;

    sa_ctrl_mem u_mem (
        .clk   (MCLK),
        .we    (mem_we),
        .waddr (sel_q),
        .wdata (WB_DAT_I[15:0]),
        .raddr (sel_q),
        .rdata (ctrl_rd)
    );

    // configuration word, holds global size and enhanced enable
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            cfg_q <= sa_buf_pkg::CFG_RST;
        end else if (wr && WB_ADR_I == sa_buf_pkg::OFS_CFG && lane01) begin
            cfg_q <= WB_DAT_I[15:0];
        end
    end

    // subaddress select
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            sel_q <= '0;
        end else if (wr && WB_ADR_I == sa_buf_pkg::OFS_SEL && WB_SEL_I[0]) begin
            sel_q <= WB_DAT_I[sa_buf_pkg::SA_W-1:0];
        end
    end

    // interrupt mask
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            mask_q <= sa_buf_pkg::MASK_RST;
        end else if (wr && WB_ADR_I == sa_buf_pkg::OFS_IRQ_MASK
                     && WB_SEL_I[0]) begin
            mask_q <= WB_DAT_I[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decode of the selected subaddress

    logic                  gsel;
    sa_buf_pkg::buf_sel_t  rx_sel;
    sa_buf_pkg::buf_sel_t  bc_sel;
    logic [2:0]            gsize;

    // RL1 global select overrides individual fields
    assign gsel   = ctrl_rd[sa_buf_pkg::GSEL_BIT];
    assign gsize  = cfg_q[sa_buf_pkg::CSIZE_LSB +: 3];
    assign rx_sel = decode_mode(gsel, ctrl_rd[sa_buf_pkg::RXM_LSB +: 3],
                                gsize);
    assign bc_sel = decode_mode(gsel, ctrl_rd[sa_buf_pkg::BCM_LSB +: 3],
                                gsize);

    ////////////////////////////////////////////////////////////////////
    // broadcast events and interrupt status

    logic [1:0] ev_set;

    // software reports message end / rollover for the selected
    // subaddress by writing the event register; a real terminal would
    // drive these from its message engine
    always_comb begin
        ev_set = 2'h0;
        if (wr && WB_ADR_I == sa_buf_pkg::OFS_EVENT && WB_SEL_I[0]) begin
            // RL5 end-of-message enable
            ev_set[0] = WB_DAT_I[sa_buf_pkg::EV_EOM_BIT]
                        && ctrl_rd[sa_buf_pkg::EOM_EN_BIT];
            // RL6 rollover only with circular mode
            ev_set[1] = WB_DAT_I[sa_buf_pkg::EV_ROLL_BIT]
                        && ctrl_rd[sa_buf_pkg::ROLL_EN_BIT]
                        && (bc_sel.mode == sa_buf_pkg::BUF_CIRC);
        end
    end

    // sticky status, cleared by read; a new event wins over the clear
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            stat_q <= 2'h0;
        end else if (rd && WB_ADR_I == sa_buf_pkg::OFS_IRQ_STAT) begin
            stat_q <= ev_set;
        end else begin
            stat_q <= stat_q | ev_set;
        end
    end

    assign IRQ = |(stat_q & mask_q);

    ////////////////////////////////////////////////////////////////////
    // read data

    // registered read mux; unmapped offsets read zero
    always_ff @(posedge MCLK or negedge ARST_N) begin
        if (!ARST_N) begin
            WB_DAT_O <= 32'h00000000;
        end else if (bus_q == BUS_WAIT) begin
            if (WB_ADR_I == sa_buf_pkg::OFS_CTRL) begin
                WB_DAT_O <= {16'h0000, ctrl_rd};
            end else if (WB_ADR_I == sa_buf_pkg::OFS_CFG) begin
                WB_DAT_O <= {16'h0000, cfg_q};
            end else if (WB_ADR_I == sa_buf_pkg::OFS_SEL) begin
                WB_DAT_O <= {27'h0000000, sel_q};
            end else if (WB_ADR_I == sa_buf_pkg::OFS_MODE) begin
                // RL10 enhanced enable shown, kept by host
                WB_DAT_O <= {cfg_q[sa_buf_pkg::ENH_BIT], 11'h000,
                             rx_sel.mode, rx_sel.size,
                             bc_sel.mode[0], 3'h0};
            end else if (WB_ADR_I == sa_buf_pkg::OFS_IRQ_STAT) begin
                WB_DAT_O <= {30'h00000000, stat_q};
            end else if (WB_ADR_I == sa_buf_pkg::OFS_IRQ_MASK) begin
                WB_DAT_O <= {30'h00000000, mask_q};
            end else begin
                WB_DAT_O <= 32'h00000000;
            end
        end
    end

endmodule // sa_buf_decode

// ===== sim/sa_buf_decode_assertions.sv
// checker: decode and interrupt properties seen at the bus ports
`timescale 1ns/1ps
module sa_buf_checker (
    input wire logic        MCLK,
    input wire logic        ARST_N,
    input wire logic        WB_CYC_I,
    input wire logic        WB_STB_I,
    input wire logic        WB_WE_I,
    input wire logic [7:0]  WB_ADR_I,
    input wire logic [3:0]  WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic [31:0] WB_DAT_O,
    input wire logic        WB_ACK_O,
    input wire logic        IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!ARST_N);
    logic [15:0] cw_q [32];
    logic [15:0] cfg_q;
    logic [4:0]  sa_q;
    logic [1:0]  msk_q;
    logic [15:0] cw;
    logic        g;
    logic        rd;
    logic        ev;
    // circular length for a size code, 128 words at the low end
    function automatic logic [13:0] sz(input logic [2:0] c);
        return sa_buf_pkg::CIRC_BASE << (c == 3'h0 ? 3'h0 : c - 3'h1);
    endfunction
    // shadow of software writes; no reset, like the control memory
    always_ff @(posedge MCLK) begin
        if (WB_ACK_O && WB_WE_I) begin
            case (WB_ADR_I)
                sa_buf_pkg::OFS_CTRL:     cw_q[sa_q] <= WB_DAT_I[15:0];
                sa_buf_pkg::OFS_CFG:      cfg_q <= WB_DAT_I[15:0];
                sa_buf_pkg::OFS_SEL:      sa_q <= WB_DAT_I[4:0];
                sa_buf_pkg::OFS_IRQ_MASK: msk_q <= WB_DAT_I[1:0];
                default: ;
            endcase
        end
    end
    // decoded-word reads and event writes
    assign cw = cw_q[sa_q];
    assign g  = cw[15];
    assign rd = WB_ACK_O && !WB_WE_I && WB_ADR_I == sa_buf_pkg::OFS_MODE;
    assign ev = WB_ACK_O && WB_WE_I && WB_ADR_I == sa_buf_pkg::OFS_EVENT;
    rx_local_a: assert property (
        rd && !g |-> WB_DAT_O[19:18] == {1'b0, cw[7:5] != 3'h0})
        else $error("rx mode wrong");
    rx_size_a: assert property (
        rd && !g && cw[7:5] != 3'h0 |-> WB_DAT_O[17:4] == sz(cw[7:5]))
        else $error("rx size wrong");
    rx_double_a: assert property (
        rd && g && cw[7:5] == 3'h0 |-> WB_DAT_O[19:18] == 2'h2)
        else $error("rx double missing");
    rx_gcirc_a: assert property (
        rd && g && cw[7:5] == 3'h7
        |-> WB_DAT_O[19:4] == {2'h1, sz(cfg_q[11:9])})
        else $error("rx global circular wrong");
    rx_fallback_a: assert property (
        rd && g && cw[7:5] != 3'h0 && cw[7:5] != 3'h7
        |-> WB_DAT_O[19:18] == 2'h0)
        else $error("rx fallback wrong");
    global_force_a: assert property (
        rd && g && (cw[7:5] == 3'h0 || cw[7:5] == 3'h7)
        |-> WB_DAT_O[19:18] != 2'h0)
        else $error("global buffering not applied");
    bc_local_a: assert property (
        rd && !g |-> WB_DAT_O[3] == (cw[2:0] != 3'h0))
        else $error("bcast mode wrong");
    bc_global_a: assert property (
        rd && g |-> WB_DAT_O[3] == (cw[2:0] == 3'h7))
        else $error("bcast global mode wrong");
    eom_irq_a: assert property (
        ev && WB_DAT_I[0] && cw[4] && msk_q[0] |-> ##[1:3] IRQ)
        else $error("end of message irq missing");
    roll_irq_a: assert property (
        ev && WB_DAT_I[1] && cw[3] && !g && cw[2:0] != 3'h0 && msk_q[1]
        |-> ##[1:3] IRQ)
        else $error("rollover irq missing");
endmodule // sa_buf_checker
bind sa_buf_decode sa_buf_checker u_chk (.MCLK(MCLK), .ARST_N(ARST_N),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .IRQ(IRQ));

// ===== sim/bc_model.sv
// bus controller model: posts message events and host accesses over wishbone
`timescale 1ns/1ps
module bc_model (
    input  wire logic        clk,
    input  wire logic        ack,
    input  wire logic [31:0] rdat,
    output logic             cyc,
    output logic             we,
    output logic [7:0]       adr,
    output logic [31:0]      wdat
);
    // idle bus at time zero
    initial begin
        cyc = 1'b0;
        we = 1'b0;
        adr = 8'h00;
        wdat = 32'h0;
    end
    // one classic cycle, held until ack; released data is inverted, not kept
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        wdat <= ~d;
    endtask
    // a broadcast message ends (bit 0) or its buffer wraps (bit 1)
    task automatic msg(input logic [1:0] e);
        logic [31:0] q;
        xfer(1'b1, sa_buf_pkg::OFS_EVENT, {30'h0, e}, q);
    endtask
endmodule // bc_model

// ===== sim/tb.sv
// testbench: decode table and broadcast interrupts through the bus
`timescale 1ns/1ps
`define CHK(v, x) begin n_compared++; if ((v) !== (x)) begin err_total++; \
    $display("unexpected at %0t got %0h exp %0h", $time, v, x); end end
module tb;
    logic        mclk = 1'b0;
    logic        arst_n = 1'b0;
    logic        cyc, we, ack, irq;
    logic [7:0]  adr;
    logic [31:0] wdat, rdat, q, e, m;
    logic [1:0]  md;
    int          err_total = 0;
    int          n_compared = 0;
    always #5 mclk = ~mclk;
    sa_buf_decode dut (.MCLK(mclk), .ARST_N(arst_n), .WB_CYC_I(cyc),
        .WB_STB_I(cyc), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .IRQ(irq));
    bc_model bc (.clk(mclk), .ack(ack), .rdat(rdat), .cyc(cyc), .we(we),
        .adr(adr), .wdat(wdat));
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bc.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a);
        bc.xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        err_total++;
        close_out();
    end
    // main sequence
    initial begin
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        `CHK(irq, 1'b0)
        // enhanced buffering on, global size code 5
        wr(sa_buf_pkg::OFS_CFG, 32'h00000A02);
        rd(8'hFC);
        `CHK(q, 32'h0)
        for (int g = 0; g < 2; g++) for (int c = 0; c < 8; c++) begin
            wr(sa_buf_pkg::OFS_SEL, 32'(c + 8 * g));
            wr(sa_buf_pkg::OFS_CTRL, {16'h0, g[0], 7'h0, c[2:0], 2'h0, c[2:0]});
            rd(sa_buf_pkg::OFS_MODE);
            md = g ? (c == 0 ? 2'h2 : c == 7 ? 2'h1 : 2'h0) : {1'b0, c != 0};
            e = {1'b1, 11'h0, md, 18'h0};
            if (md == 2'h1) e[17:4] = 14'h80 << (g ? 4 : c - 1);
            e[3] = g ? c == 7 : c != 0;
            m = md == 2'h1 ? 32'hFFFFFFFF : 32'hFFFC000F;
            `CHK(q & m, e)
        end
        $display("decode test done");
        wr(sa_buf_pkg::OFS_CTRL, 32'h00000019);
        wr(sa_buf_pkg::OFS_IRQ_MASK, 32'h0);
        bc.msg(2'h1);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b0)
        rd(sa_buf_pkg::OFS_IRQ_STAT);
        `CHK(q[1:0], 2'h1)
        rd(sa_buf_pkg::OFS_IRQ_STAT);
        `CHK(q[1:0], 2'h0)
        wr(sa_buf_pkg::OFS_IRQ_MASK, 32'h3);
        bc.msg(2'h2);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b1)
        rd(sa_buf_pkg::OFS_IRQ_STAT);
        `CHK(q[1:0], 2'h2)
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b0)
        // end of message with the mask open must interrupt
        bc.msg(2'h1);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b1)
        rd(sa_buf_pkg::OFS_IRQ_STAT);
        `CHK(q[1:0], 2'h1)
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b0)
        // enables off: neither event may interrupt
        wr(sa_buf_pkg::OFS_CTRL, 32'h00000001);
        bc.msg(2'h3);
        repeat (3) @(posedge mclk);
        `CHK(irq, 1'b0)
        $display("irq test done");
        close_out();
    end
endmodule // tb
